// file: hdl/dsp_pointer_address_gen.sv
// module: dsp pointer address generation datapath with apb registers
`timescale 1ns/1ps
`default_nettype none
module dsp_pointer_address_gen (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // mac operand request from the core pipeline
    input wire logic I_OP_VALID,
    input wire logic I_OP_PTR_SEL,
    input wire logic I_OP_OFS_SEL,
    input wire logic [4:0] I_OP_MODE,
    input wire logic I_OP_PAR_MOVE,
    input wire logic I_OP_INDIRECT,
    // store instruction word
    input wire logic I_STORE_VALID,
    input wire logic [31:0] I_STORE_INSTR,
    // results
    output logic O_STALL,
    output logic O_ADDR_VALID,
    output logic [15:0] O_LONG_ADDR,
    output logic [23:0] O_PHYS_ADDR,
    output logic [15:0] O_MOVE_ADDR,
    output logic O_STORE_VALID,
    output logic [5:0] O_STORE_REG_SEL,
    output logic O_STORE_ILLEGAL
);

    // ****************************************************************
    // functions
    // ****************************************************************

    // one-hot mac register select, all zero for undefined codes
    // the select bit order is this block's own; the codes are fixed
    function automatic logic [5:0] store_decode(input logic [4:0] code);
        logic [5:0] sel;
        sel = 6'h00;
        if (code == dsp_agu_pkg::CODE_STAT_WORD) begin
            sel = 6'h01;
        end else if (code == dsp_agu_pkg::CODE_ACC_HIGH) begin
            sel = 6'h02;
        end else if (code == dsp_agu_pkg::CODE_ACC_HIGH_SAT) begin
            sel = 6'h04;
        end else if (code == dsp_agu_pkg::CODE_ACC_LOW) begin
            sel = 6'h08;
        end else if (code == dsp_agu_pkg::CODE_CTRL_WORD) begin
            sel = 6'h10;
        end else if (code == dsp_agu_pkg::CODE_REPEAT_WORD) begin
            sel = 6'h20;
        end
        return sel;
    endfunction : store_decode

    // clear bit 0 to keep a word aligned value
    // used on every pointer and offset write, so bit 0 never holds a one
    function automatic logic [15:0] word_align(input logic [15:0] v);
        return {v[15:1], 1'b0};
    endfunction : word_align

    // data page words sit in their own slot, one aligned word each
    // the same test guards the error answer, the write and the read
    function automatic logic page_hit(input logic [7:0] a);
        return (a[7:4] == dsp_agu_pkg::OFFS_DATA_PAGE[7:4]) && (a[1:0] == 2'h0);
    endfunction : page_hit

    // ****************************************************************
    // state
    // ****************************************************************

    // software visible registers, each with its next value beside it
    logic [15:0] offset_reg_zero_reg; // offset register zero
    logic [15:0] offset_reg_zero_next;
    logic [15:0] offset_reg_one_reg; // offset register one
    logic [15:0] offset_reg_one_next;
    logic [15:0] index_pointer_zero_reg; // index pointer zero
    logic [15:0] index_pointer_zero_next;
    logic [15:0] index_pointer_one_reg; // index pointer one
    logic [15:0] index_pointer_one_next;
    logic [9:0] data_page_reg_reg [4]; // four data page registers
    logic [9:0] data_page_reg_next [4];
    logic [2:0] page_ovr_reg; // bit2 enable, bits1:0 forced page select
    logic [2:0] page_ovr_next;
    logic [1:0] stall_cnt_reg; // init stall countdown
    logic [1:0] stall_cnt_next;
    logic [31:0] prdata_reg; // read data, loaded in the setup cycle
    logic [31:0] prdata_next;
    // registered results towards the core pipeline
    logic addr_valid_reg; // operand address strobe
    logic addr_valid_next;
    logic [15:0] long_addr_reg;
    logic [15:0] long_addr_next;
    logic [23:0] phys_addr_reg;
    logic [23:0] phys_addr_next;
    logic [15:0] move_addr_reg;
    logic [15:0] move_addr_next;
    // store decode results
    logic store_valid_reg; // decoded store strobe
    logic store_valid_next;
    logic [5:0] store_sel_reg;
    logic [5:0] store_sel_next;
    logic store_ill_reg;
    logic store_ill_next;

    // ****************************************************************
    // apb decode and bus signals
    // ****************************************************************

    // bus phase decode; the slave never inserts a wait state
    logic apb_access; // access phase
    logic apb_wr; // write takes effect
    logic apb_rd; // read seen in its setup cycle
    logic mapped; // address hits a register
    logic [15:0] wdata16;
    logic op_take; // operand accepted this cycle

    always_comb begin
        apb_access = I_PSEL && I_PENABLE;
        apb_wr = apb_access && I_PWRITE;
        // a read is looked up one edge early so that its data leaves a flip-flop
        apb_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
        wdata16 = I_PWDATA[15:0];
        // address decode: only real registers answer without error
        if (I_PADDR == dsp_agu_pkg::OFFS_OFFSET_ZERO) begin
            mapped = 1'b1; // offset register zero
        end else if (I_PADDR == dsp_agu_pkg::OFFS_OFFSET_ONE) begin
            mapped = 1'b1; // offset register one
        end else if (I_PADDR == dsp_agu_pkg::OFFS_INDEX_ZERO) begin
            mapped = 1'b1; // index pointer zero
        end else if (I_PADDR == dsp_agu_pkg::OFFS_INDEX_ONE) begin
            mapped = 1'b1; // index pointer one
        end else if (I_PADDR == dsp_agu_pkg::OFFS_PAGE_OVR) begin
            mapped = 1'b1; // page override control
        end else if (I_PADDR == dsp_agu_pkg::OFFS_STATUS) begin
            mapped = 1'b1; // read-only stall status
        end else if (page_hit(I_PADDR)) begin
            mapped = 1'b1; // four data page words
        end else begin
            mapped = 1'b0; // hole in the map
        end
        // stall also blocks a new operand during init
        op_take = I_OP_VALID && I_OP_INDIRECT && (stall_cnt_reg == 2'h0);
    end

    // ****************************************************************
    // register file and pointer update
    // ****************************************************************

    // operand path working values, all settled within one cycle
    logic [15:0] ptr; // selected pointer
    logic [15:0] ofs; // paired offset
    logic [15:0] step; // step for this mode
    logic [15:0] ptr_upd; // written back pointer
    logic [15:0] mv; // intermediate move address
    logic [1:0] page_sel; // data page in use

    always_comb begin
        offset_reg_zero_next = offset_reg_zero_reg;
        offset_reg_one_next = offset_reg_one_reg;
        index_pointer_zero_next = index_pointer_zero_reg;
        index_pointer_one_next = index_pointer_one_reg;
        for (int i = 0; i < 4; i++) begin
            data_page_reg_next[i] = data_page_reg_reg[i];
        end
        page_ovr_next = page_ovr_reg;
        // stall count runs down to zero and rests there
        stall_cnt_next = (stall_cnt_reg != 2'h0) ? stall_cnt_reg - 2'h1 : 2'h0;
        prdata_next = prdata_reg;
        // operand path: pick pointer and offset, then work out both addresses
        // every step and offset is even, so word alignment only guards wrap
        ptr = I_OP_PTR_SEL ? index_pointer_one_reg : index_pointer_zero_reg;
        ofs = I_OP_OFS_SEL ? offset_reg_one_reg : offset_reg_zero_reg;
        step = 16'h0000;
        ptr_upd = ptr;
        mv = ptr;
        // one-hot mode; an unknown code behaves as plain addressing
        case (I_OP_MODE)
            dsp_agu_pkg::MODE_POST_INC: begin
                step = dsp_agu_pkg::WORD_STEP;
                ptr_upd = ptr + step;
                mv = ptr - step;
            end
            dsp_agu_pkg::MODE_POST_DEC: begin
                step = dsp_agu_pkg::WORD_STEP;
                ptr_upd = ptr - step;
                mv = ptr + step;
            end
            dsp_agu_pkg::MODE_OFS_INC: begin
                ptr_upd = ptr + ofs;
                mv = ptr - ofs;
            end
            dsp_agu_pkg::MODE_OFS_DEC: begin
                ptr_upd = ptr - ofs;
                mv = ptr + ofs;
            end
            default: begin
                ptr_upd = ptr; // plain mode, no update
            end
        endcase
        ptr_upd = word_align(ptr_upd);
        // an override in force replaces the page picked by the pointer top bits
        page_sel = page_ovr_reg[2] ? page_ovr_reg[1:0] : ptr[15:14];
        // own adder, independent of the gpr unit
        // only a taken operand writes its pointer back
        if (op_take) begin
            if (I_OP_PTR_SEL) begin
                index_pointer_one_next = ptr_upd;
            end else begin
                index_pointer_zero_next = ptr_upd;
            end
        end
        // apb writes override a same cycle pointer update, so software wins
        // offset and pointer writes raise a short stall before the next operand
        if (apb_wr) begin
            if (I_PADDR == dsp_agu_pkg::OFFS_OFFSET_ZERO) begin
                offset_reg_zero_next = word_align(wdata16);
                stall_cnt_next = dsp_agu_pkg::INIT_STALL_CYCLES;
            end else if (I_PADDR == dsp_agu_pkg::OFFS_OFFSET_ONE) begin
                offset_reg_one_next = word_align(wdata16);
                stall_cnt_next = dsp_agu_pkg::INIT_STALL_CYCLES;
            end else if (I_PADDR == dsp_agu_pkg::OFFS_INDEX_ZERO) begin
                index_pointer_zero_next = word_align(wdata16);
                stall_cnt_next = dsp_agu_pkg::INIT_STALL_CYCLES;
            end else if (I_PADDR == dsp_agu_pkg::OFFS_INDEX_ONE) begin
                index_pointer_one_next = word_align(wdata16);
                stall_cnt_next = dsp_agu_pkg::INIT_STALL_CYCLES;
            end else if (I_PADDR == dsp_agu_pkg::OFFS_PAGE_OVR) begin
                page_ovr_next = I_PWDATA[2:0];
            end else if (page_hit(I_PADDR)) begin
                data_page_reg_next[I_PADDR[3:2]] = I_PWDATA[9:0]; // one of four pages
            end
        end
        // apb read data, looked up in the setup cycle
        // an operand update on that very edge is not seen by this read
        if (apb_rd) begin
            if (I_PADDR == dsp_agu_pkg::OFFS_OFFSET_ZERO) begin
                prdata_next = {16'h0000, offset_reg_zero_reg};
            end else if (I_PADDR == dsp_agu_pkg::OFFS_OFFSET_ONE) begin
                prdata_next = {16'h0000, offset_reg_one_reg};
            end else if (I_PADDR == dsp_agu_pkg::OFFS_INDEX_ZERO) begin
                prdata_next = {16'h0000, index_pointer_zero_reg};
            end else if (I_PADDR == dsp_agu_pkg::OFFS_INDEX_ONE) begin
                prdata_next = {16'h0000, index_pointer_one_reg};
            end else if (I_PADDR == dsp_agu_pkg::OFFS_PAGE_OVR) begin
                prdata_next = {29'h00000000, page_ovr_reg};
            end else if (I_PADDR == dsp_agu_pkg::OFFS_STATUS) begin
                prdata_next = {30'h00000000, stall_cnt_reg};
            end else if (page_hit(I_PADDR)) begin
                prdata_next = {22'h000000, data_page_reg_reg[I_PADDR[3:2]]};
            end else begin
                prdata_next = 32'h00000000;
            end
        end
        // address outputs, registered one edge after the operand is taken
        // long and physical addresses use the pointer before its update
        addr_valid_next = op_take;
        long_addr_next = op_take ? ptr : long_addr_reg;
        phys_addr_next = op_take ? {data_page_reg_reg[page_sel], ptr[13:0]}
                                 : phys_addr_reg;
        move_addr_next = (op_take && I_OP_PAR_MOVE) ? word_align(mv)
                                                    : move_addr_reg;
        // store decode, one edge behind the instruction word
        // codes with no register raise the illegal flag instead
        store_valid_next = I_STORE_VALID;
        store_sel_next = I_STORE_VALID ? store_decode(
            I_STORE_INSTR[dsp_agu_pkg::STORE_FIELD_MSB:dsp_agu_pkg::STORE_FIELD_LSB])
            : 6'h00;
        store_ill_next = I_STORE_VALID && (store_sel_next == 6'h00);
    end

    // ****************************************************************
    // registers
    // ****************************************************************

    // all state registered here
    // reset loads constants only, so the reset branch stays free of logic
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            offset_reg_zero_reg <= dsp_agu_pkg::RST_OFFSET;
            offset_reg_one_reg <= dsp_agu_pkg::RST_OFFSET;
            index_pointer_zero_reg <= dsp_agu_pkg::RST_INDEX;
            index_pointer_one_reg <= dsp_agu_pkg::RST_INDEX;
            for (int i = 0; i < 4; i++) begin
                data_page_reg_reg[i] <= dsp_agu_pkg::RST_DATA_PAGE;
            end
            page_ovr_reg <= 3'h0;
            stall_cnt_reg <= 2'h0;
            prdata_reg <= 32'h00000000;
            addr_valid_reg <= 1'b0;
            long_addr_reg <= 16'h0000;
            phys_addr_reg <= 24'h000000;
            move_addr_reg <= 16'h0000;
            store_valid_reg <= 1'b0;
            store_sel_reg <= 6'h00;
            store_ill_reg <= 1'b0;
        end else begin
            // load every next value on each edge
            offset_reg_zero_reg <= offset_reg_zero_next;
            offset_reg_one_reg <= offset_reg_one_next;
            index_pointer_zero_reg <= index_pointer_zero_next;
            index_pointer_one_reg <= index_pointer_one_next;
            for (int i = 0; i < 4; i++) begin
                data_page_reg_reg[i] <= data_page_reg_next[i];
            end
            page_ovr_reg <= page_ovr_next;
            stall_cnt_reg <= stall_cnt_next;
            prdata_reg <= prdata_next;
            addr_valid_reg <= addr_valid_next;
            long_addr_reg <= long_addr_next;
            phys_addr_reg <= phys_addr_next;
            move_addr_reg <= move_addr_next;
            store_valid_reg <= store_valid_next;
            store_sel_reg <= store_sel_next;
            store_ill_reg <= store_ill_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    // apb answers in the first access cycle, so no wait state is ever inserted
    // read data was captured at the setup edge and stands through the access cycle
    // holes in the map answer with an error and read as zero, leaving every other register alone
    always_comb begin
        O_PREADY = 1'b1; // zero wait states
        O_PSLVERR = apb_access && !mapped; // unmapped address
        O_PRDATA = prdata_reg; // registered read data
        O_STALL = stall_cnt_reg != 2'h0;
        O_ADDR_VALID = addr_valid_reg;
        O_LONG_ADDR = long_addr_reg;
        O_PHYS_ADDR = phys_addr_reg;
        O_MOVE_ADDR = move_addr_reg;
        O_STORE_VALID = store_valid_reg;
        O_STORE_REG_SEL = store_sel_reg;
        O_STORE_ILLEGAL = store_ill_reg;
    end

endmodule : dsp_pointer_address_gen
`default_nettype wire

// file: hdl/dsp_agu_pkg.sv
// package: constants for the dsp pointer address generator
package dsp_agu_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFFS_OFFSET_ZERO = 8'h00;
    localparam logic [7:0] OFFS_OFFSET_ONE = 8'h04;
    localparam logic [7:0] OFFS_INDEX_ZERO = 8'h08;
    localparam logic [7:0] OFFS_INDEX_ONE = 8'h0C;
    localparam logic [7:0] OFFS_DATA_PAGE = 8'h20; // four page words up to 0x2C
    localparam logic [7:0] OFFS_PAGE_OVR = 8'h14;
    localparam logic [7:0] OFFS_STATUS = 8'h18;
    // reset values
    localparam logic [15:0] RST_OFFSET = 16'h0000;
    localparam logic [15:0] RST_INDEX = 16'h0000;
    localparam logic [9:0] RST_DATA_PAGE = 10'h000;
    // field positions
    localparam int PAGE_SEL_MSB = 15;
    localparam int PAGE_SEL_LSB = 14;
    localparam int PAGE_OFS_MSB = 13;
    localparam int STORE_FIELD_MSB = 31;
    localparam int STORE_FIELD_LSB = 27;
    // fixed pointer step for word accesses
    localparam logic [15:0] WORD_STEP = 16'h0002;
    // cycles an offset or pointer write blocks following address work
    localparam logic [1:0] INIT_STALL_CYCLES = 2'h1;
    // pointer update modes
    typedef enum logic [4:0] {
        MODE_PLAIN = 5'h01,
        MODE_POST_INC = 5'h02,
        MODE_POST_DEC = 5'h04,
        MODE_OFS_INC = 5'h08,
        MODE_OFS_DEC = 5'h10
    } upd_mode_t;
    // mac unit register codes
    localparam logic [4:0] CODE_STAT_WORD = 5'h00;
    localparam logic [4:0] CODE_ACC_HIGH = 5'h01;
    localparam logic [4:0] CODE_ACC_HIGH_SAT = 5'h02;
    localparam logic [4:0] CODE_ACC_LOW = 5'h04;
    localparam logic [4:0] CODE_CTRL_WORD = 5'h05;
    localparam logic [4:0] CODE_REPEAT_WORD = 5'h06;
endpackage : dsp_agu_pkg

// file: bench/dsp_agu_checker.sv
// checker: port assertions for the dsp pointer address generator
`timescale 1ns/1ps
`default_nettype none
module dsp_agu_checker (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic I_OP_VALID,
    input wire logic I_STORE_VALID,
    input wire logic O_STALL,
    input wire logic O_ADDR_VALID,
    input wire logic [15:0] O_LONG_ADDR,
    input wire logic [23:0] O_PHYS_ADDR,
    input wire logic O_STORE_VALID,
    input wire logic [5:0] O_STORE_REG_SEL,
    input wire logic O_STORE_ILLEGAL
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    // read completing at the ready edge
    logic rd_done;
    assign rd_done = I_PSEL && I_PENABLE && !I_PWRITE && O_PREADY;
    a_offset_lsb_zero: assert property (rd_done && I_PADDR[7:3] == 5'h00
        |-> O_PRDATA[0] == 1'b0) else $error("offset register bit 0 read as one");
    a_index_lsb_zero: assert property (rd_done && I_PADDR[7:3] == 5'h01
        |-> O_PRDATA[0] == 1'b0) else $error("index pointer bit 0 read as one");
    a_long_addr_even: assert property (O_ADDR_VALID |-> !O_LONG_ADDR[0])
        else $error("long address odd");
    a_page_offset_kept: assert property (O_ADDR_VALID
        |-> O_PHYS_ADDR[13:0] == O_LONG_ADDR[13:0]) else $error("page offset lost");
    a_store_sel_onehot: assert property (O_STORE_VALID |-> $onehot0(O_STORE_REG_SEL))
        else $error("store select not one hot");
    a_store_illegal_flag: assert property (O_STORE_VALID
        |-> O_STORE_ILLEGAL == (O_STORE_REG_SEL == 6'h00)) else $error("illegal flag wrong");
    a_stall_bounded: assert property ($rose(O_STALL) |-> ##[1:8] !O_STALL)
        else $error("stall never ends");
    a_addr_answer: assert property (I_OP_VALID && !O_STALL |-> ##[0:4] O_ADDR_VALID)
        else $error("operand address missing");
    a_store_answer: assert property ($rose(I_STORE_VALID) |-> ##[0:4] O_STORE_VALID)
        else $error("store decode missing");
    a_offset_write_stall: assert property (I_PSEL && I_PENABLE && I_PWRITE && O_PREADY
        && (I_PADDR == 8'h00 || I_PADDR == 8'h04) |=> O_STALL)
        else $error("no stall after offset write");
endmodule : dsp_agu_checker
bind dsp_pointer_address_gen dsp_agu_checker dsp_agu_checker_i (.I_CORE_CLK, .I_RST_N,
    .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .O_PRDATA, .O_PREADY, .I_OP_VALID,
    .I_STORE_VALID, .O_STALL, .O_ADDR_VALID, .O_LONG_ADDR, .O_PHYS_ADDR, .O_STORE_VALID,
    .O_STORE_REG_SEL, .O_STORE_ILLEGAL);
`default_nettype wire

// file: bench/core_pipe_model.sv
// partner: core pipeline model issuing mac operand and store requests
`timescale 1ns/1ps
`default_nettype none
module core_pipe_model (
    input wire logic i_clk,
    input wire logic i_stall,
    output logic o_op_valid,
    output logic o_ptr_sel,
    output logic o_ofs_sel,
    output logic [4:0] o_mode,
    output logic o_par,
    output logic o_indirect,
    output logic o_st_valid,
    output logic [31:0] o_st_instr
);
    // idle pipeline at time zero
    initial begin
        o_op_valid = 1'b0;
        {o_ptr_sel, o_ofs_sel, o_mode, o_par, o_indirect} = 9'h000;
        o_st_valid = 1'b0;
        o_st_instr = 32'h00000000;
    end
    // operand request, held until an edge sees no stall
    task automatic issue_op(input logic p, input logic q, input logic [4:0] m, input logic mv);
        @(posedge i_clk);
        o_op_valid <= 1'b1;
        {o_ptr_sel, o_ofs_sel, o_mode, o_par, o_indirect} <= {p, q, m, mv, 1'b1};
        do @(posedge i_clk); while (i_stall !== 1'b0);
        o_op_valid <= 1'b0;
        {o_ptr_sel, o_ofs_sel, o_mode, o_par} <= ~{p, q, m, mv};
    endtask : issue_op
    // store instruction word, one cycle wide
    task automatic issue_store(input logic [31:0] w);
        @(posedge i_clk);
        o_st_valid <= 1'b1;
        o_st_instr <= w;
        @(posedge i_clk);
        o_st_valid <= 1'b0;
        o_st_instr <= ~w;
    endtask : issue_store
endmodule : core_pipe_model
`default_nettype wire

// file: bench/tb_dsp_pointer_address_gen.sv
// testbench: self-checking bench for the dsp pointer address generator
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_pointer_address_gen;
    typedef struct {logic [31:0] d; logic e; logic w;} apb_note_t;
    typedef struct {logic [15:0] la; logic [15:0] ma; logic mv; logic [23:0] pa;} op_note_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, st_instr;
    logic pready, pslverr, op_valid, ptr_sel, ofs_sel, par, ind, st_in, stall;
    logic addr_valid, st_valid, st_ill;
    logic [4:0] mode;
    logic [15:0] long_addr, move_addr;
    logic [23:0] phys_addr;
    logic [5:0] st_sel;
    logic [5:0] sel_seen = 6'h00;
    apb_note_t apq[$];
    apb_note_t an;
    op_note_t opq[$];
    op_note_t on;
    logic stq[$];
    logic [15:0] ptr [2];
    logic [15:0] ofs [2];
    logic [9:0] dp [4];
    logic [2:0] ovr = 3'h0;
    int mismatches = 0;
    int num_checks = 0;
    always #20 clk = ~clk;
    dsp_pointer_address_gen dsp_pointer_address_gen_i (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_OP_VALID(op_valid), .I_OP_PTR_SEL(ptr_sel), .I_OP_OFS_SEL(ofs_sel),
        .I_OP_MODE(mode), .I_OP_PAR_MOVE(par), .I_OP_INDIRECT(ind),
        .I_STORE_VALID(st_in), .I_STORE_INSTR(st_instr), .O_STALL(stall),
        .O_ADDR_VALID(addr_valid), .O_LONG_ADDR(long_addr), .O_PHYS_ADDR(phys_addr),
        .O_MOVE_ADDR(move_addr), .O_STORE_VALID(st_valid), .O_STORE_REG_SEL(st_sel),
        .O_STORE_ILLEGAL(st_ill));
    core_pipe_model pipe_i (.i_clk(clk), .i_stall(stall), .o_op_valid(op_valid),
        .o_ptr_sel(ptr_sel), .o_ofs_sel(ofs_sel), .o_mode(mode), .o_par(par),
        .o_indirect(ind), .o_st_valid(st_in), .o_st_instr(st_instr));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // apb master transfer, expected result noted first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] x, input logic er);
        apq.push_back('{x, er, w});
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {psel, penable, pwdata} <= {1'b0, 1'b0, ~d};
    endtask : apb
    // one mac operand request, then pointer read back
    task automatic do_op(input logic p, input logic q, input logic [4:0] m, input logic mv);
        logic [15:0] b, d, ma, nx;
        logic [23:0] pa;
        b = ptr[p];
        pa = {ovr[2] ? dp[ovr[1:0]] : dp[b[15:14]], b[13:0]};
        d = (m[1] | m[2]) ? dsp_agu_pkg::WORD_STEP : (m[0] ? 16'h0000 : ofs[q]);
        if (m[1] | m[3]) begin
            ma = b - d;
            nx = b + d;
        end else begin
            ma = b + d;
            nx = b - d;
        end
        opq.push_back('{b, ma, mv, pa});
        pipe_i.issue_op(p, q, m, mv);
        for (int n = 0; n < 6 && addr_valid !== 1'b1; n++) @(posedge clk);
        repeat (2) @(posedge clk);
        ptr[p] = nx;
        apb(1'b0, 8'h08 + 8'(4 * p), 32'h0, {16'h0000, nx}, 1'b0);
    endtask : do_op
    // output watcher: oldest note against each result
    always @(posedge clk) begin
        if (rst_n && psel && penable && pready === 1'b1 && apq.size() > 0) begin
            an = apq.pop_front();
            if (!an.w) chk("prdata", prdata, an.d);
            chk("pslverr", {31'h0, pslverr}, {31'h0, an.e});
        end
        if (rst_n && addr_valid === 1'b1 && opq.size() > 0) begin
            on = opq.pop_front();
            chk("long_addr", {16'h0, long_addr}, {16'h0, on.la});
            chk("page_ofs", {18'h0, phys_addr[13:0]}, {18'h0, on.la[13:0]});
            chk("phys_addr", {8'h0, phys_addr}, {8'h0, on.pa});
            if (on.mv) chk("move_addr", {16'h0, move_addr}, {16'h0, on.ma});
        end
        if (rst_n && st_valid === 1'b1 && stq.size() > 0) begin
            chk("store_none", {31'h0, st_sel == 6'h00}, {31'h0, stq[0]});
            chk("store_ill", {31'h0, st_ill}, {31'h0, stq.pop_front()});
            sel_seen <= sel_seen | st_sel;
        end
    end
    // main sequence
    initial begin
        logic [31:0] r;
        void'($urandom(32'h7D49AB7C));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a += 4) apb(1'b0, 8'(a), 32'h0, 32'h0, 1'b0);
        apb(1'b1, 8'h30, 32'h1, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            dp[i] = r[9:0];
            apb(1'b1, dsp_agu_pkg::OFFS_DATA_PAGE + 8'(4 * i), r, 32'h0, 1'b0);
        end
        apb(1'b0, dsp_agu_pkg::OFFS_DATA_PAGE + 8'h0C, 32'h0, {22'h0, dp[3]}, 1'b0);
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 4 && k % 10 == 0; i++) begin
                r = (k == 0 && i > 0) ? 32'h0000FFFF : $urandom;
                apb(1'b1, 8'(4 * i), r, 32'h0, 1'b0);
                if (i < 2) ofs[i] = r[15:0] & 16'hFFFE;
                else ptr[i - 2] = r[15:0] & 16'hFFFE;
            end
            if (k == 20) begin
                ovr = 3'h4 | 3'($urandom);
                apb(1'b1, dsp_agu_pkg::OFFS_PAGE_OVR, {29'h0, ovr}, 32'h0, 1'b0);
            end
            do_op(1'($urandom), 1'($urandom), 5'h01 << (k % 5), 1'($urandom));
        end
        for (int c = 0; c < 32; c++) begin
            stq.push_back(!(c inside {0, 1, 2, 4, 5, 6}));
            r = $urandom;
            pipe_i.issue_store({5'(c), r[26:0]});
            for (int n = 0; n < 6 && st_valid !== 1'b1; n++) @(posedge clk);
            @(posedge clk);
        end
        chk("ops_left", opq.size(), 32'h0);
        chk("stores_left", stq.size(), 32'h0);
        chk("sel_seen", {26'h0, sel_seen}, 32'h3F);
        test_done();
    end
    // watchdog against a hang
    initial begin
        #400000;
        mismatches++;
        test_done();
    end
endmodule : tb_dsp_pointer_address_gen
`default_nettype wire
